// ===== src/watchdog_and_low_voltage_hold.v
// watchdog reset and low-voltage hold supervisor for a small controller core
// assumes all inputs synchronous to REF_CLK; the supply detector and core are outside
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_regs.vh"

module watchdog_and_low_voltage_hold #(
  parameter [`EXPIRY_CNT_W-1:0] TERM_CYC = `EXPIRY_TERM_CYC
) (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // controller core
  input wire TIMER_CLEAR,
  output wire CORE_RUN,
  output wire INSTR_BOUNDARY,
  // supply detector
  input wire LOW_VOLTAGE,
  // chip-level outputs
  output wire CHIP_RESET,
  output wire RING_OSC_RUN,
  output wire HOLD_ACTIVE,
  output wire HOLD_PENDING,
  output wire TIMER_RESET_SEEN
);

  // ----------------------------------------
  // hold states
  // ----------------------------------------
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_DRAIN = 2'b01;
  localparam [1:0] ST_HOLD = 2'b10;

  localparam [`PHASE_W-1:0] PHASE_LAST = `INSTR_PHASE_LAST;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`PHASE_W-1:0] phase_q;
  reg [`PHASE_W-1:0] phase_d;
  reg core_run_q;
  reg boundary_q;
  reg pending_q;
  reg hold_q;
  reg osc_run_q;
  reg [`RST_CNT_W-1:0] rst_cnt_q;
  reg chip_reset_q;
  reg timer_seen_q;

  wire timer_expire;
  wire timer_clear;
  wire in_reset;
  wire at_boundary;
  wire frozen;
  wire hold_next;
  wire drain_next;
  wire core_run_d;

  assign in_reset = chip_reset_q;
  assign frozen = (state_q == ST_HOLD);
  assign at_boundary = !frozen && (phase_q == PHASE_LAST);
  assign timer_clear = TIMER_CLEAR || in_reset;
  assign hold_next = (state_d == ST_HOLD);
  assign drain_next = (state_d == ST_DRAIN);
  // expiry stops the core at once, on the same edge that raises the reset pulse
  assign core_run_d = !hold_next && !in_reset && !timer_expire;

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // held cleared while the chip reset pulse is out, so it restarts at release
  expiry_reset_timer #(
    .TERM_CYC(TERM_CYC)
  ) u_timer (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .clear(timer_clear),
    .freeze(frozen),
    .expire_q(timer_expire),
    .count()
  );

  // ----------------------------------------
  // chip reset pulse
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_cnt_q <= `RST_CNT_ZERO;
      chip_reset_q <= 1'b0;
      timer_seen_q <= 1'b0;
    end
    else if (timer_expire)
    begin
      rst_cnt_q <= `RST_PULSE_CYC - `RST_CNT_ONE;
      chip_reset_q <= 1'b1;
      timer_seen_q <= 1'b1;
    end
    else if (rst_cnt_q != `RST_CNT_ZERO)
    begin
      rst_cnt_q <= rst_cnt_q - `RST_CNT_ONE;
    end
    else
    begin
      chip_reset_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // instruction phase and hold control
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    phase_d = phase_q;
    if (in_reset)
    begin
      state_d = ST_RUN;
      phase_d = `PHASE_ZERO;
    end
    else
    begin
      // phase does not move in hold, so the core resumes at phase zero, the start of an instruction
      if (!frozen)
      begin
        if (phase_q == PHASE_LAST)
        begin
          phase_d = `PHASE_ZERO;
        end
        else
        begin
          phase_d = phase_q + 7'h01;
        end
      end
      case (state_q)
        ST_RUN:
        begin
          if (LOW_VOLTAGE && at_boundary)
          begin
            state_d = ST_HOLD;
          end
          else if (LOW_VOLTAGE)
          begin
            state_d = ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          if (!LOW_VOLTAGE)
          begin
            state_d = ST_RUN;
          end
          else if (at_boundary)
          begin
            state_d = ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          // release needs no boundary: the phase was parked at zero on entry
          if (!LOW_VOLTAGE)
          begin
            state_d = ST_RUN;
          end
        end
        default:
        begin
          state_d = ST_RUN;
        end
      endcase
    end
  end

  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q <= ST_RUN;
      phase_q <= `PHASE_ZERO;
      core_run_q <= 1'b0;
      boundary_q <= 1'b0;
      pending_q <= 1'b0;
      hold_q <= 1'b0;
      osc_run_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      // core runs only outside hold and outside the reset pulse
      core_run_q <= core_run_d;
      boundary_q <= at_boundary && !in_reset;
      pending_q <= drain_next;
      hold_q <= hold_next;
      osc_run_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign CORE_RUN = core_run_q;
  assign INSTR_BOUNDARY = boundary_q;
  assign CHIP_RESET = chip_reset_q;
  assign RING_OSC_RUN = osc_run_q;
  assign HOLD_ACTIVE = hold_q;
  assign HOLD_PENDING = pending_q;
  assign TIMER_RESET_SEEN = timer_seen_q;

endmodule // watchdog_and_low_voltage_hold

`default_nettype wire

// ===== src/supervisor_regs.vh
// constants for the watchdog and low-voltage hold supervisor
// assumes a single free-running reference clock and no software-visible registers
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH

// ----------------------------------------
// clock
// ----------------------------------------
`define CLK_HZ 25'h17d_7840
`define CLK_PERIOD_NS 6'h28

// ----------------------------------------
// instruction cycle
// ----------------------------------------
// 4000 ns at 40 ns a clock: 100 clocks, phases 0 to 99
`define INSTR_CYCLE_NS 12'hfa0
`define INSTR_PHASE_LAST 7'h63
`define PHASE_W 7
`define PHASE_ZERO 7'h00

// ----------------------------------------
// watchdog terminal count
// ----------------------------------------
// one second of clocks, sized so no width is dropped at the parameter
`define EXPIRY_TERM_MS 10'h3e8
`define EXPIRY_TERM_CYC 25'h17d_7840
`define EXPIRY_CNT_W 25
`define EXPIRY_CNT_ZERO 25'h000_0000
`define EXPIRY_CNT_ONE 25'h000_0001

// ----------------------------------------
// chip reset pulse
// ----------------------------------------
`define RST_PULSE_CYC 4'h8
`define RST_CNT_W 4
`define RST_CNT_ZERO 4'h0
`define RST_CNT_ONE 4'h1

`endif

// ===== src/expiry_reset_timer.v
// terminal-count timer behind the chip watchdog
// assumes clear may stay high for the whole chip reset pulse and freeze comes from the hold logic
`timescale 1ns/10ps
`default_nettype none
`include "supervisor_regs.vh"

module expiry_reset_timer #(
  parameter [`EXPIRY_CNT_W-1:0] TERM_CYC = `EXPIRY_TERM_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire clear,
  input wire freeze,
  // status
  output reg expire_q,
  output wire [`EXPIRY_CNT_W-1:0] count
);

  reg [`EXPIRY_CNT_W-1:0] cnt_q;
  wire [`EXPIRY_CNT_W-1:0] term_last;

  assign term_last = TERM_CYC - `EXPIRY_CNT_ONE;
  assign count = cnt_q;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // no enable input: nothing outside clear or hold can stop it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= `EXPIRY_CNT_ZERO;
      expire_q <= 1'b0;
    end
    else if (clear)
    begin
      cnt_q <= `EXPIRY_CNT_ZERO;
      expire_q <= 1'b0;
    end
    else if (freeze)
    begin
      expire_q <= 1'b0;
    end
    else if (cnt_q == term_last)
    begin
      cnt_q <= `EXPIRY_CNT_ZERO;
      expire_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + `EXPIRY_CNT_ONE;
      expire_q <= 1'b0;
    end
  end

endmodule // expiry_reset_timer

`default_nettype wire

// ===== dv/supervisor_checker.sv
// port checker for the supervisor
// assumes bind onto the top module below
`timescale 1ns/10ps
`default_nettype none
module supervisor_checker (
  // clock, reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // inputs
  input wire logic LOW_VOLTAGE,
  // outputs
  input wire logic CORE_RUN,
  input wire logic INSTR_BOUNDARY,
  input wire logic CHIP_RESET,
  input wire logic RING_OSC_RUN,
  input wire logic HOLD_ACTIVE,
  input wire logic TIMER_RESET_SEEN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // cycles spent waiting for hold; a reset pulse restarts the wait
  logic [7:0] wait_q;
  always @(posedge REF_CLK or negedge RESETN)
    if (!RESETN)
      wait_q <= 8'h00;
    else
      wait_q <= (LOW_VOLTAGE && !HOLD_ACTIVE && !CHIP_RESET) ? wait_q + 8'h01 : 8'h00;
  sequence s_pulse;
    CHIP_RESET [*8] ##1 !CHIP_RESET;
  endsequence
  property p_pulse;
    $rose(CHIP_RESET) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse length");
  property p_core;
    CHIP_RESET |-> !CORE_RUN;
  endproperty
  a_core: assert property (p_core) else $error("core runs in reset");
  property p_seen;
    $rose(CHIP_RESET) |-> TIMER_RESET_SEEN;
  endproperty
  a_seen: assert property (p_seen) else $error("seen flag");
  property p_osc;
    $past(RESETN) |-> RING_OSC_RUN;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator stopped");
  property p_frz;
    HOLD_ACTIVE && $past(HOLD_ACTIVE) |-> !CORE_RUN && !INSTR_BOUNDARY && !CHIP_RESET;
  endproperty
  a_frz: assert property (p_frz) else $error("state moved in hold");
  property p_ent;
    $rose(HOLD_ACTIVE) |-> INSTR_BOUNDARY && $past(LOW_VOLTAGE);
  endproperty
  a_ent: assert property (p_ent) else $error("hold off boundary");
  property p_exit;
    HOLD_ACTIVE && !LOW_VOLTAGE |=> !HOLD_ACTIVE && CORE_RUN;
  endproperty
  a_exit: assert property (p_exit) else $error("hold release");
  property p_wait;
    wait_q <= 8'h65;
  endproperty
  a_wait: assert property (p_wait) else $error("hold too late");
endmodule // supervisor_checker
bind watchdog_and_low_voltage_hold supervisor_checker supervisor_checker_inst (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .LOW_VOLTAGE(LOW_VOLTAGE), .CORE_RUN(CORE_RUN),
  .INSTR_BOUNDARY(INSTR_BOUNDARY), .CHIP_RESET(CHIP_RESET), .RING_OSC_RUN(RING_OSC_RUN),
  .HOLD_ACTIVE(HOLD_ACTIVE), .TIMER_RESET_SEEN(TIMER_RESET_SEEN));
`default_nettype wire

// ===== dv/core_model.sv
// controller core and supply detector stand-in
// assumes the bench sets the clear gap and the supply level
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic [7:0] gap,
  input wire logic low,
  output logic clr,
  output logic lv
);
  logic [7:0] n = 8'h00;
  // gap of zero means software stopped clearing; the count parks at zero
  // so clearing resumes at once when a gap is set again
  always @(negedge clk)
  begin
    clr = (gap != 8'h00) && (n == 8'h00);
    n = (gap == 8'h00 || n >= gap) ? 8'h00 : n + 8'h01;
  end
  assign lv = low;
endmodule // core_model
`default_nettype wire

// ===== dv/tb.sv
// testbench for the supervisor
// assumes terminal count shortened to 200 cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] gap = 8'h00;
  logic low = 1'b0;
  logic clr, lv, run, bnd, crst, osc, hact, hpnd, seen;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #20 clk = ~clk;
  core_model core_model_inst (.clk(clk), .gap(gap), .low(low), .clr(clr), .lv(lv));
  watchdog_and_low_voltage_hold #(.TERM_CYC(25'h00c8)) watchdog_and_low_voltage_hold_inst (
    .REF_CLK(clk), .RESETN(rstn), .TIMER_CLEAR(clr), .CORE_RUN(run), .INSTR_BOUNDARY(bnd),
    .LOW_VOLTAGE(lv), .CHIP_RESET(crst), .RING_OSC_RUN(osc), .HOLD_ACTIVE(hact),
    .HOLD_PENDING(hpnd), .TIMER_RESET_SEEN(seen));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_expire;
    int n = 0;
    while (crst !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk(n >= 200 && n <= 203, 1);
    chk({seen, run}, 2'b10);
    // let the pulse run out before the next scenario looks for resets
    n = 0;
    while (crst !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, 8);
  endtask
  task automatic t_clear;
    logic hit = 1'b0;
    gap = 8'h96;
    repeat (700) @(negedge clk) hit |= crst;
    chk(hit, 0);
  endtask
  task automatic t_hold;
    int n = 0;
    logic bad = 1'b0;
    @(posedge bnd);
    @(negedge clk);
    low = 1'b1;
    while (hact !== 1'b1 && n < 120)
    begin
      @(negedge clk);
      n++;
    end
    chk(n <= 101, 1);
    gap = 8'h00;
    // longer than the terminal count: a running watchdog would fire
    repeat (300) @(negedge clk) bad |= crst | run | ~osc | ~hact;
    chk(bad, 0);
    gap = 8'h96;
    low = 1'b0;
    repeat (2) @(negedge clk);
    chk({hact, run, osc}, 3'b011);
  endtask
  task automatic t_abort;
    int n = 0;
    logic bad = 1'b0;
    @(posedge bnd);
    // the boundary pulse still stands one falling edge after its rise
    repeat (2) @(negedge clk);
    while (bnd !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, 99);
    low = 1'b1;
    repeat (2) @(negedge clk);
    chk({hpnd, hact}, 2'b10);
    low = 1'b0;
    repeat (110) @(negedge clk) bad |= hact;
    chk(bad, 0);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      error_cnt++;
      final_report;
    end
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk({osc, run, crst}, 3'b110);
    t_expire;
    t_clear;
    t_hold;
    t_abort;
    final_report;
  end
endmodule // tb
`default_nettype wire
